// ===== dcu_pkg.sv
// Constants, command codes and state encoding of the debug command unit
`default_nettype none
package dcu_pkg;
    // -----------------------------------------------------------------
    // Register map and fields
    // -----------------------------------------------------------------
    localparam logic [3:0] CTL_OFS    = 4'h0;
    localparam logic [3:0] STAT_OFS   = 4'h4;
    localparam int         HALT_BIT   = 7;
    localparam int         BREAK_OPCODE_ENABLE_BIT  = 6;
    localparam int         DACK_BIT   = 5;
    localparam int         RST_BIT    = 0;
    localparam int         SEL_LANE   = 0;
    // -----------------------------------------------------------------
    // Command codes
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_RDMEM  = 8'h0D;
    localparam logic [7:0] CMD_CRC    = 8'h0E;
    localparam logic [7:0] CMD_STEP   = 8'h10;
    localparam logic [7:0] CMD_STUFF  = 8'h11;
    localparam logic [7:0] CMD_EXEC   = 8'h12;
    localparam logic [7:0] CMD_WPW    = 8'h20;
    localparam logic [7:0] CMD_WPR    = 8'h21;
    // -----------------------------------------------------------------
    // Data values
    // -----------------------------------------------------------------
    localparam logic [7:0]  BLANK_BYTE = 8'hFF;
    localparam logic [15:0] BLANK_CRC  = 16'hFFFF;
    localparam logic [15:0] CRC_POLY   = 16'h1021;
    localparam logic [15:0] CRC_INIT   = 16'hFFFF;
    localparam int          PMEM_BYTES = 65536;
    localparam int          FIFO_DEPTH = 16;
    localparam int          BYTE_W     = 8;
    // -----------------------------------------------------------------
    // Command parser states
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h00, ST_RD_AH   = 5'h01, ST_RD_AL   = 5'h02,
        ST_RD_SH  = 5'h03, ST_RD_SL   = 5'h04, ST_RD_REQ  = 5'h05,
        ST_RD_WT  = 5'h06, ST_CRC_REQ = 5'h07, ST_CRC_WT  = 5'h08,
        ST_CRC_HI = 5'h09, ST_CRC_LO  = 5'h0A, ST_STUFF   = 5'h0B,
        ST_EX_1ST = 5'h0C, ST_EX_LEN  = 5'h0D, ST_EX_MORE = 5'h0E,
        ST_EX_DROP= 5'h0F, ST_WP_CTL  = 5'h10, ST_WP_ADR  = 5'h11,
        ST_WP_VAL = 5'h12, ST_WR_CTL  = 5'h13, ST_WR_ADR  = 5'h14,
        ST_WR_VAL = 5'h15
    } dcu_state_t;
endpackage
`default_nettype wire

// ===== dcu_core.sv
// Debug command unit: byte command parser, control register, reply FIFO
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`default_nettype none
// Overview of operation
// - Memory read: address, size, zero size means 65536
// - Not halted: memory read returns FFH bytes
// - Checksum returns program memory CRC-CCITT, upper first
// - Not halted: checksum returns FFFFH
// - Checksum reply waits for whole memory pass
// - Step runs one instruction unless not allowed
// - Stuff runs host opcode unless not allowed
// - Execute forwards instruction, else drops one byte
// - Watch write; not allowed forces control zero
// - Watch read returns control, address, value
// - 81H reset halted, 41H reset run, 40H resumes
// - Control bits 7,6,5 R/W, 0 reset, zero reset
// - Halt bit stops CPU instruction fetch
// - Break opcode or watch break sets halt
// - Read protect blocks clearing halt by write
// - Watchdog reloaded continuously while halted

// ---------------------------------------------------------------------
// Reply FIFO
// ---------------------------------------------------------------------
module dcu_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } dcu_fifo_t;
    dcu_fifo_t q_reg, q_next;
    logic push, pop;

    // Handshake flags
    assign in_ready  = (q_reg.cnt != (AW+1)'(D));
    assign out_valid = (q_reg.cnt != '0);
    assign out_data  = q_reg.mem[q_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        q_next = q_reg;
        if (push) begin
            q_next.mem[q_reg.wp] = in_data;
            q_next.wp = q_reg.wp + 1'b1;
        end
        if (pop) begin
            q_next.rp = q_reg.rp + 1'b1;
        end
        q_next.cnt = q_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule

// ---------------------------------------------------------------------
// Command unit top
// ---------------------------------------------------------------------
module dcu_core #(
    parameter int PMEM_SIZE = dcu_pkg::PMEM_BYTES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_data,
    output logic             dmem_req,
    output logic      [15:0] dmem_addr,
    input  wire logic        dmem_ack,
    input  wire logic [7:0]  dmem_rdata,
    output logic             pmem_req,
    output logic      [15:0] pmem_addr,
    input  wire logic        pmem_ack,
    input  wire logic [7:0]  pmem_rdata,
    input  wire logic        read_protect,
    input  wire logic        break_opcode_seen,
    input  wire logic        watch_break,
    input  wire logic [2:0]  instr_len,
    output logic             cpu_halt,
    output logic             cpu_step,
    output logic             cpu_stuff,
    output logic      [7:0]  stuff_opcode,
    output logic             exec_valid,
    output logic      [7:0]  exec_byte,
    output logic             cpu_reset,
    output logic             wdt_reload,
    output logic      [7:0]  watch_match_control,
    output logic      [7:0]  watch_match_address,
    output logic      [7:0]  watch_match_value
);
    typedef struct packed {
        dcu_pkg::dcu_state_t st;
        logic        halt;
        logic        break_opcode_enable;
        logic        dack;
        logic [15:0] addr;
        logic [15:0] cnt;
        logic [15:0] crc;
        logic [16:0] pcnt;
        logic [2:0]  left;
        logic [7:0]  wctl;
        logic [7:0]  wadr;
        logic [7:0]  wval;
        logic        ov;
        logic [7:0]  od;
        logic        txv;
        logic [7:0]  txd;
        logic        dreq;
        logic        preq;
        logic        step;
        logic        stuff;
        logic [7:0]  sop;
        logic        exv;
        logic [7:0]  exd;
        logic        crst;
        logic        wdt;
        logic        ack;
        logic [31:0] rdat;
    } dcu_core_t;
    dcu_core_t q_reg, q_next;

    logic       f_in_rdy;
    logic       f_ov;
    logic [7:0] f_od;
    logic       f_pop;
    logic       allowed;
    logic       can_emit;
    logic       wb_req;
    logic       ctl_wr;

    // CRC-CCITT over one byte, MSB first
    function automatic logic [15:0] crc_byte(
        input logic [15:0] c,
        input logic [7:0]  d
    );
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ dcu_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Reply FIFO and output stage
    // ------------------------------------------------------------------
    dcu_fifo #(
        .W (dcu_pkg::BYTE_W),
        .D (dcu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (q_reg.ov),
        .in_ready  (f_in_rdy),
        .in_data   (q_reg.od),
        .out_valid (f_ov),
        .out_ready (f_pop),
        .out_data  (f_od)
    );

    // Shared decode terms
    assign f_pop    = !q_reg.txv || tx_ready;
    assign allowed  = q_reg.halt && !read_protect;
    assign can_emit = !q_reg.ov;
    assign wb_req   = wb_cyc_i && wb_stb_i && !q_reg.ack;
    assign ctl_wr   = wb_req && wb_we_i && (wb_adr_i == dcu_pkg::CTL_OFS)
                      && wb_sel_i[dcu_pkg::SEL_LANE];

    // Next-state logic
    always_comb begin
        q_next       = q_reg;
        q_next.step  = 1'b0;
        q_next.stuff = 1'b0;
        q_next.exv   = 1'b0;
        q_next.crst  = 1'b0;
        q_next.wdt   = q_reg.halt;
        q_next.ack   = wb_req;
        // Reply path toward the serialiser
        if (q_reg.ov && f_in_rdy) begin
            q_next.ov = 1'b0;
        end
        if (q_reg.txv && tx_ready) begin
            q_next.txv = 1'b0;
        end
        if (f_ov && f_pop) begin
            q_next.txv = 1'b1;
            q_next.txd = f_od;
        end
        // Register bus reads
        if (wb_req && wb_adr_i == dcu_pkg::CTL_OFS) begin
            q_next.rdat = '0;
            q_next.rdat[dcu_pkg::HALT_BIT]  = q_reg.halt;
            q_next.rdat[dcu_pkg::BREAK_OPCODE_ENABLE_BIT] = q_reg.break_opcode_enable;
            q_next.rdat[dcu_pkg::DACK_BIT]  = q_reg.dack;
        end else if (wb_req && wb_adr_i == dcu_pkg::STAT_OFS) begin
            q_next.rdat = {27'h0000000, q_reg.st};
        end else if (wb_req) begin
            q_next.rdat = '0;
        end
        // Control register write
        if (ctl_wr) begin
            q_next.break_opcode_enable = wb_dat_i[dcu_pkg::BREAK_OPCODE_ENABLE_BIT];
            q_next.dack  = wb_dat_i[dcu_pkg::DACK_BIT];
            q_next.crst  = wb_dat_i[dcu_pkg::RST_BIT];
            if (!(read_protect && q_reg.halt)) begin
                q_next.halt = wb_dat_i[dcu_pkg::HALT_BIT];
            end
        end
        // Hardware set of halt wins over a clearing write
        if ((break_opcode_seen && q_reg.break_opcode_enable) || watch_break) begin
            q_next.halt = 1'b1;
        end
        // Command parser
        case (q_reg.st)
            dcu_pkg::ST_IDLE: begin
                if (rx_valid) begin
                    case (rx_data)
                        dcu_pkg::CMD_RDMEM: q_next.st = dcu_pkg::ST_RD_AH;
                        dcu_pkg::CMD_CRC: begin
                            q_next.pcnt = '0;
                            if (q_reg.halt) begin
                                q_next.crc = dcu_pkg::CRC_INIT;
                                q_next.st  = dcu_pkg::ST_CRC_REQ;
                            end else begin
                                q_next.crc = dcu_pkg::BLANK_CRC;
                                q_next.st  = dcu_pkg::ST_CRC_HI;
                            end
                        end
                        dcu_pkg::CMD_STEP: q_next.step = allowed;
                        dcu_pkg::CMD_STUFF: q_next.st = dcu_pkg::ST_STUFF;
                        dcu_pkg::CMD_EXEC: begin
                            q_next.st = allowed ? dcu_pkg::ST_EX_1ST
                                                : dcu_pkg::ST_EX_DROP;
                        end
                        dcu_pkg::CMD_WPW: q_next.st = dcu_pkg::ST_WP_CTL;
                        dcu_pkg::CMD_WPR: q_next.st = dcu_pkg::ST_WR_CTL;
                        default: q_next.st = dcu_pkg::ST_IDLE;
                    endcase
                end
            end
            // Address and size, high byte first
            dcu_pkg::ST_RD_AH: begin
                if (rx_valid) begin
                    q_next.addr[15:8] = rx_data;
                    q_next.st = dcu_pkg::ST_RD_AL;
                end
            end
            dcu_pkg::ST_RD_AL: begin
                if (rx_valid) begin
                    q_next.addr[7:0] = rx_data;
                    q_next.st = dcu_pkg::ST_RD_SH;
                end
            end
            dcu_pkg::ST_RD_SH: begin
                if (rx_valid) begin
                    q_next.cnt[15:8] = rx_data;
                    q_next.st = dcu_pkg::ST_RD_SL;
                end
            end
            dcu_pkg::ST_RD_SL: begin
                if (rx_valid) begin
                    q_next.cnt[7:0] = rx_data;
                    q_next.st = dcu_pkg::ST_RD_REQ;
                end
            end
            dcu_pkg::ST_RD_REQ: begin
                if (can_emit && q_reg.halt) begin
                    q_next.dreq = 1'b1;
                    q_next.st   = dcu_pkg::ST_RD_WT;
                end else if (can_emit) begin
                    q_next.ov   = 1'b1;
                    q_next.od   = dcu_pkg::BLANK_BYTE;
                    q_next.addr = q_reg.addr + 16'h0001;
                    q_next.cnt  = q_reg.cnt - 16'h0001;
                    if (q_reg.cnt == 16'h0001) begin
                        q_next.st = dcu_pkg::ST_IDLE;
                    end
                end
            end
            dcu_pkg::ST_RD_WT: begin
                if (dmem_ack) begin
                    q_next.dreq = 1'b0;
                    q_next.ov   = 1'b1;
                    q_next.od   = dmem_rdata;
                    q_next.addr = q_reg.addr + 16'h0001;
                    q_next.cnt  = q_reg.cnt - 16'h0001;
                    q_next.st   = (q_reg.cnt == 16'h0001)
                                  ? dcu_pkg::ST_IDLE : dcu_pkg::ST_RD_REQ;
                end
            end
            // Whole program memory pass, one byte per access
            dcu_pkg::ST_CRC_REQ: begin
                q_next.preq = 1'b1;
                q_next.st   = dcu_pkg::ST_CRC_WT;
            end
            dcu_pkg::ST_CRC_WT: begin
                if (pmem_ack) begin
                    q_next.preq = 1'b0;
                    q_next.crc  = crc_byte(q_reg.crc, pmem_rdata);
                    q_next.pcnt = q_reg.pcnt + 17'h00001;
                    q_next.st   = (q_reg.pcnt == 17'(PMEM_SIZE - 1))
                                  ? dcu_pkg::ST_CRC_HI : dcu_pkg::ST_CRC_REQ;
                end
            end
            dcu_pkg::ST_CRC_HI: begin
                if (can_emit) begin
                    q_next.ov = 1'b1;
                    q_next.od = q_reg.crc[15:8];
                    q_next.st = dcu_pkg::ST_CRC_LO;
                end
            end
            dcu_pkg::ST_CRC_LO: begin
                if (can_emit) begin
                    q_next.ov = 1'b1;
                    q_next.od = q_reg.crc[7:0];
                    q_next.st = dcu_pkg::ST_IDLE;
                end
            end
            // Opcode byte is always consumed
            dcu_pkg::ST_STUFF: begin
                if (rx_valid) begin
                    q_next.stuff = allowed;
                    q_next.sop   = rx_data;
                    q_next.st    = dcu_pkg::ST_IDLE;
                end
            end
            dcu_pkg::ST_EX_1ST: begin
                if (rx_valid) begin
                    q_next.exv = 1'b1;
                    q_next.exd = rx_data;
                    q_next.st  = dcu_pkg::ST_EX_LEN;
                end
            end
            // CPU decodes length of the opcode just shown
            dcu_pkg::ST_EX_LEN: begin
                q_next.left = instr_len - 3'h1;
                q_next.st   = (instr_len > 3'h1)
                              ? dcu_pkg::ST_EX_MORE : dcu_pkg::ST_IDLE;
            end
            dcu_pkg::ST_EX_MORE: begin
                if (rx_valid) begin
                    q_next.exv  = 1'b1;
                    q_next.exd  = rx_data;
                    q_next.left = q_reg.left - 3'h1;
                    if (q_reg.left == 3'h1) begin
                        q_next.st = dcu_pkg::ST_IDLE;
                    end
                end
            end
            dcu_pkg::ST_EX_DROP: begin
                if (rx_valid) begin
                    q_next.st = dcu_pkg::ST_IDLE;
                end
            end
            // Watch write: control, address, value
            dcu_pkg::ST_WP_CTL: begin
                if (rx_valid) begin
                    q_next.cnt[7:0] = rx_data;
                    q_next.st = dcu_pkg::ST_WP_ADR;
                end
            end
            dcu_pkg::ST_WP_ADR: begin
                if (rx_valid) begin
                    q_next.addr[7:0] = rx_data;
                    q_next.st = dcu_pkg::ST_WP_VAL;
                end
            end
            dcu_pkg::ST_WP_VAL: begin
                if (rx_valid) begin
                    q_next.wctl = allowed ? q_reg.cnt[7:0] : 8'h00;
                    q_next.wadr = q_reg.addr[7:0];
                    q_next.wval = rx_data;
                    q_next.st   = dcu_pkg::ST_IDLE;
                end
            end
            // Watch read: control, address, value
            dcu_pkg::ST_WR_CTL: begin
                if (can_emit) begin
                    q_next.ov = 1'b1;
                    q_next.od = q_reg.wctl;
                    q_next.st = dcu_pkg::ST_WR_ADR;
                end
            end
            dcu_pkg::ST_WR_ADR: begin
                if (can_emit) begin
                    q_next.ov = 1'b1;
                    q_next.od = q_reg.wadr;
                    q_next.st = dcu_pkg::ST_WR_VAL;
                end
            end
            dcu_pkg::ST_WR_VAL: begin
                if (can_emit) begin
                    q_next.ov = 1'b1;
                    q_next.od = q_reg.wval;
                    q_next.st = dcu_pkg::ST_IDLE;
                end
            end
            default: q_next.st = dcu_pkg::ST_IDLE;
        endcase
    end

    // State register; every field clears on reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from state flip-flops
    // ------------------------------------------------------------------
    assign wb_dat_o            = q_reg.rdat;
    assign wb_ack_o            = q_reg.ack;
    assign tx_valid            = q_reg.txv;
    assign tx_data             = q_reg.txd;
    assign dmem_req            = q_reg.dreq;
    assign dmem_addr           = q_reg.addr;
    assign pmem_req            = q_reg.preq;
    assign pmem_addr           = q_reg.pcnt[15:0];
    assign cpu_halt            = q_reg.halt;
    assign cpu_step            = q_reg.step;
    assign cpu_stuff           = q_reg.stuff;
    assign stuff_opcode        = q_reg.sop;
    assign exec_valid          = q_reg.exv;
    assign exec_byte           = q_reg.exd;
    assign cpu_reset           = q_reg.crst;
    assign wdt_reload          = q_reg.wdt;
    assign watch_match_control = q_reg.wctl;
    assign watch_match_address = q_reg.wadr;
    assign watch_match_value   = q_reg.wval;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !q_reg.ack;
    endsequence
    sequence cmd_s(logic [7:0] code);
        q_reg.st == dcu_pkg::ST_IDLE && rx_valid && rx_data == code;
    endsequence

    wb_ack_a: assert property (wb_req_s |=> q_reg.ack ##1 !q_reg.ack)
        else $error("bus ack not a single cycle");
    break_set_a: assert property (
        (break_opcode_seen && q_reg.break_opcode_enable) || watch_break |=> q_reg.halt)
        else $error("halt not set on break");
    protect_hold_a: assert property (
        ctl_wr && read_protect && q_reg.halt |=> q_reg.halt)
        else $error("halt cleared under read protect");
    wdt_reload_a: assert property (
        q_reg.halt |=> wdt_reload)
        else $error("watchdog not reloaded while halted");
    reset_pulse_a: assert property (
        ctl_wr && wb_dat_i[dcu_pkg::RST_BIT] |=> cpu_reset ##1 !cpu_reset)
        else $error("reset request not one pulse");
    step_gate_a: assert property (
        cmd_s(dcu_pkg::CMD_STEP) |=> cpu_step == $past(allowed))
        else $error("step issued against mode");
    blank_read_a: assert property (
        q_reg.st == dcu_pkg::ST_RD_REQ && can_emit && !q_reg.halt
        |=> q_reg.ov && q_reg.od == dcu_pkg::BLANK_BYTE)
        else $error("read not blank when running");
    blank_crc_a: assert property (
        cmd_s(dcu_pkg::CMD_CRC) && !q_reg.halt
        |=> q_reg.st == dcu_pkg::ST_CRC_HI
            && q_reg.crc == dcu_pkg::BLANK_CRC)
        else $error("checksum not blank when running");
    watch_clear_a: assert property (
        q_reg.st == dcu_pkg::ST_WP_VAL && rx_valid && !allowed
        |=> watch_match_control == 8'h00)
        else $error("watch control not forced to zero");
endmodule
`default_nettype wire

// ===== dcu_host.sv
// Debug host model that sends command bytes and reads replies
`default_nettype none
module dcu_host (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    // Slow reader, takes a reply byte every other cycle
    always @(posedge clk) tx_ready <= ~tx_ready;
    // One byte per call, data inverted once released
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
endmodule
`default_nettype wire

// ===== tb_dcu_core.sv
// Self-checking bench of the debug command unit
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_dcu_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_valid;
    logic tx_valid, tx_ready, dmem_req, dmem_ack, pmem_req, pmem_ack;
    logic cpu_halt, cpu_step, cpu_reset, wdt_reload;
    logic cpu_stuff, exec_valid, rp, break_opcode;
    logic [7:0] stuff_opcode, exec_byte;
    logic [3:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [7:0] rx_data, tx_data, dmem_rdata, pmem_rdata;
    logic [15:0] dmem_addr, pmem_addr;
    logic [2:0] k;
    int num_errors, compares;
    dcu_core #(.PMEM_SIZE(16)) u_dcu_core (.clk, .reset, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rx_valid, .rx_data, .tx_valid, .tx_ready,
        .tx_data, .dmem_req, .dmem_addr, .dmem_ack, .dmem_rdata, .pmem_req,
        .pmem_addr, .pmem_ack, .pmem_rdata, .read_protect(rp),
        .break_opcode_seen(break_opcode), .watch_break(1'b0), .instr_len(3'h1),
        .cpu_halt, .cpu_step, .cpu_stuff, .stuff_opcode, .exec_valid,
        .exec_byte, .cpu_reset, .wdt_reload, .watch_match_control(),
        .watch_match_address(), .watch_match_value());
    dcu_host u_dcu_host (.clk, .rx_valid, .rx_data, .tx_ready);
    // Memory responders, one-cycle ack pulse
    always @(posedge clk) begin
        dmem_ack   <= dmem_req & ~dmem_ack;
        dmem_rdata <= dmem_addr[7:0] ^ 8'h5A;
        pmem_ack   <= pmem_req & ~pmem_ack;
        pmem_rdata <= pmem_addr[7:0];
    end
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 20) begin num_errors++; wrap_up(); end
    endtask
    task automatic cmd(input logic [7:0] b[$]);
        foreach (b[i]) u_dcu_host.send(b[i]);
    endtask
    task automatic recv(input logic [7:0] e);
        int n;
        n = 0;
        do begin @(posedge clk); n++; end
        while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 3000);
        if (n >= 3000) begin num_errors++; wrap_up(); end
        `CHK(tx_data, e)
    endtask
    // Count pulses of step or reset over four cycles
    task automatic hits(input bit r);
        k = 3'h0;
        repeat (4) begin @(posedge clk); k += {2'h0, r ? cpu_reset : cpu_step}; end
    endtask
    // Reference CRC over the modelled program memory, bit by bit
    function automatic logic [15:0] crc_ref();
        logic [15:0] c;
        c = dcu_pkg::CRC_INIT;
        for (int n = 0; n < 16; n++) begin
            for (int i = 7; i >= 0; i--) begin
                c = {c[14:0], 1'b0}
                    ^ ((c[15] ^ n[i]) ? dcu_pkg::CRC_POLY : 16'h0000);
            end
        end
        return c;
    endfunction
    task automatic t_regs;
        wb(1'b0, dcu_pkg::CTL_OFS, 8'h00); `CHK(q, 32'h00000000)
        wb(1'b1, dcu_pkg::CTL_OFS, 8'hFE);
        wb(1'b0, dcu_pkg::CTL_OFS, 8'h00); `CHK(q, 32'h000000E0)
        wb(1'b1, dcu_pkg::CTL_OFS, 8'h00); `CHK(cpu_halt, 1'b0)
        wb(1'b0, 4'hC, 8'h00); `CHK(q, 32'h00000000)
    endtask
    task automatic t_free;
        cmd('{8'h11, 8'hA5}); @(posedge clk);
        `CHK(cpu_stuff, 1'b0)
        cmd('{8'h12, 8'h77}); @(posedge clk);
        `CHK(exec_valid, 1'b0)
        cmd('{8'h20, 8'h5A, 8'h33, 8'h44});
        cmd('{8'h21}); recv(8'h00); recv(8'h33); recv(8'h44);
        cmd('{8'h0D, 8'h00, 8'h10, 8'h00, 8'h02});
        recv(8'hFF); recv(8'hFF);
        cmd('{8'h0E}); recv(8'hFF); recv(8'hFF);
        cmd('{8'h10}); hits(1'b0); `CHK(k, 3'h0)
    endtask
    task automatic t_halt;
        wb(1'b1, dcu_pkg::CTL_OFS, 8'h81); `CHK(cpu_reset, 1'b1)
        hits(1'b1); `CHK(k, 3'h0)
        wb(1'b0, dcu_pkg::CTL_OFS, 8'h00); `CHK(q, 32'h00000080)
        `CHK({cpu_halt, wdt_reload}, 2'b11)
        cmd('{8'h10}); hits(1'b0); `CHK(k, 3'h1)
        cmd('{8'h0E}); q[15:0] = crc_ref();
        recv(q[15:8]); recv(q[7:0]);
        cmd('{8'h11, 8'hA5}); @(posedge clk);
        `CHK({cpu_stuff, stuff_opcode}, 9'h1A5)
        cmd('{8'h12, 8'h77}); @(posedge clk);
        `CHK({exec_valid, exec_byte}, 9'h177)
        cmd('{8'h0D, 8'h00, 8'h12, 8'h00, 8'h01}); recv(8'h48);
        cmd('{8'h20, 8'h5A, 8'h33, 8'h44});
        cmd('{8'h21}); recv(8'h5A); recv(8'h33); recv(8'h44);
        wb(1'b1, dcu_pkg::CTL_OFS, 8'h40); @(posedge clk);
        `CHK(cpu_halt, 1'b0)
        break_opcode <= 1'b1;
        @(posedge clk);
        break_opcode <= 1'b0;
        @(posedge clk);
        `CHK(cpu_halt, 1'b1)
        rp <= 1'b1;
        wb(1'b1, dcu_pkg::CTL_OFS, 8'h00);
        `CHK(cpu_halt, 1'b1)
        cmd('{8'h10}); hits(1'b0); `CHK(k, 3'h0)
    endtask
    initial begin
        {clk, reset, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b01000;
        {dmem_ack, pmem_ack, rp, break_opcode, wb_adr_i, wb_dat_i} = '0;
        {dmem_rdata, pmem_rdata, num_errors, compares} = '0;
        fork forever #20 clk = ~clk; join_none
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_free();
        t_halt();
        wrap_up();
    end
endmodule
`default_nettype wire
